// ==== hdl/fec_regs.svh ====
`ifndef FEC_REGS_SVH
`define FEC_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define FEC_ADDR_LOW_OFS 8'hAC
`define FEC_ADDR_HIGH_OFS 8'hAD
`define FEC_CONTROL_OFS 8'hAE
`define FEC_WDATA_OFS 8'hAF
`define FEC_TIMING_OFS 8'hAB
// ****************************************
// control fields
// ****************************************
`define FEC_CTL_BUSY 7
`define FEC_CTL_SWP 6
`define FEC_CTL_CRD 4
`define FEC_CTL_WRITE 1
`define FEC_CTL_ERASE 0
`define FEC_CTL_RW_MASK 8'h3C
// ****************************************
// lock byte fields
// ****************************************
`define FEC_LOCK_BOOT 4
`define FEC_LOCK_SIZE_HI 3
`define FEC_LOCK_SIZE_LO 1
`define FEC_LOCK_DBG 0
`define FEC_LOCK_RSV_MASK 8'hE0
`define FEC_INFO_LOCK_ADDR 13'h0000
// ****************************************
// reset values and timing
// ****************************************
`define FEC_TIMING_RST 6'h2A
`define FEC_ERASE_TIME_MS 20
`define FEC_WRITE_TIME_US 20
`define FEC_CLK_MHZ 200
`define FEC_ERASE_CYCLES (`FEC_ERASE_TIME_MS * 1000 * `FEC_CLK_MHZ)
`define FEC_WRITE_CYCLES (`FEC_WRITE_TIME_US * `FEC_CLK_MHZ)
`define FEC_TIMING_REF 42
`endif

// ==== hdl/fec_pkg.sv ====
package fec_pkg;
    typedef enum logic [5:0] {
        FEC_IDLE = 6'h01,
        FEC_ERASE = 6'h02,
        FEC_ARM = 6'h04,
        FEC_COLLECT = 6'h08,
        FEC_PROG = 6'h10,
        FEC_DONE = 6'h20
    } fec_state_t;
    typedef logic [7:0] fec_byte_t;
endpackage

// ==== hdl/fec_lock_check.sv ====
`timescale 1ns/10ps
`include "fec_regs.svh"
// combinational protection check of one page against the lock byte
module fec_lock_check
    import fec_pkg::*;
(
    // lock byte and page
    input wire logic [7:0] i_lock,
    input wire logic [5:0] i_page,
    // result
    output logic o_protected
);
    logic [2:0] size;
    logic upper;
    always_comb begin
        size = i_lock[`FEC_LOCK_SIZE_HI:`FEC_LOCK_SIZE_LO];
        case (size)
            3'h0: upper = 1'b1;
            3'h1: upper = i_page >= 6'd32;
            3'h2: upper = i_page >= 6'd48;
            3'h3: upper = i_page >= 6'd56;
            3'h4: upper = i_page >= 6'd60;
            3'h5: upper = i_page >= 6'd62;
            3'h6: upper = i_page == 6'd63;
            default: upper = 1'b0;
        endcase
        // boot page protected by its own bit, or by size 000 covering all
        o_protected = upper || ((i_page == 6'h00) && !i_lock[`FEC_LOCK_BOOT]);
    end
endmodule

// ==== hdl/fec_timer.sv ====
`timescale 1ns/10ps
`include "fec_regs.svh"
// timing generator: cycle count scaled by the timing value against the reference
module fec_timer
    import fec_pkg::*;
#(
    parameter int ERASE_CYCLES = `FEC_ERASE_CYCLES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // control
    input wire logic i_start,
    input wire logic i_erase,
    input wire logic [5:0] i_timing,
    // status
    output logic o_done
);
    logic [31:0] cnt_q, cnt_d;
    logic run_q, run_d;
    logic done_q, done_d;
    // a lower timing value (slower cpu) shortens the span in our clock
    function automatic logic [31:0] scale(input logic [31:0] cyc, input logic [5:0] t);
        logic [37:0] p;
        p = 38'(cyc) * 38'(t);
        scale = 32'(p / 38'(`FEC_TIMING_REF)) + 32'd1;
    endfunction
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (i_start) begin
            run_d = 1'b1;
            cnt_d = i_erase ? scale(32'(ERASE_CYCLES), i_timing)
                            : scale(32'(`FEC_WRITE_CYCLES), i_timing);
        end else if (run_q) begin
            if (cnt_q <= 32'd1) begin
                run_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 32'd1;
            end
        end
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 32'h0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end
    assign o_done = done_q;
endmodule

// ==== hdl/fec_controller.sv ====
`timescale 1ns/10ps
`include "fec_regs.svh"
// Functional notes
// - erase start erases page from high bits 6:1
// - erase and write together: erase first
// - control bit 7 reads busy
// - erase held about 20 ms
// - stall flash fetch during operation
// - lock byte written once, debug only
// - lock byte at info zero, bits 7:5 reserved
// - boot lock bit 4 protects page 0
// - lock size protects upper pages
// - debug lock bit 0 disables debug
// - lock byte written via data, info page selected
// - timing from 6-bit timing value
// - timing value resets to 0x2A
// - dma trigger after each word committed
// - bit 6 busy during single word write
// - bit 4 keeps read enables on
// - start bits read zero, write starts
// - data forwarded only after write start
// - address splits into page, row, location
// - array write every four bytes
// - 64 pages of 2048 bytes
module fec_controller
    import fec_pkg::*;
#(
    parameter int ERASE_CYCLES = `FEC_ERASE_CYCLES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // special-function register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // cpu fetch side
    input wire logic i_fetch_from_flash,
    output logic o_fetch_stall,
    // debug side
    input wire logic i_dbg_access,
    input wire logic i_dbg_info_page,
    input wire logic i_chip_erase,
    output logic o_dbg_enable,
    // dma
    output logic o_dma_trigger,
    // flash array
    output logic o_flash_erase,
    output logic o_flash_prog,
    output logic o_flash_info,
    output logic [5:0] o_flash_page,
    output logic [2:0] o_flash_row,
    output logic [5:0] o_flash_word,
    output logic [31:0] o_flash_wdata,
    output logic o_flash_read_en
);
    // ****************************************
    // registers
    // ****************************************
    fec_state_t state_q, state_d;
    fec_byte_t addr_lo_q, addr_lo_d, addr_hi_q, addr_hi_d;
    fec_byte_t ctl_q, ctl_d, wdata_q, wdata_d, lock_q, lock_d;
    logic [5:0] timing_q, timing_d;
    logic [1:0] bcnt_q, bcnt_d;
    logic [31:0] word_q, word_d;
    logic pend_wr_q, pend_wr_d, info_q, info_d, lock_used_q, lock_used_d;
    logic stall_q, stall_d, dma_q, dma_d, erase_q, erase_d, prog_q, prog_d;
    logic [7:0] rdata_q, rdata_d;
    logic rden_q, rden_d;
    logic tim_start, tim_erase, tim_done, prot, busy;
    logic [5:0] page;
    logic [12:0] loc;
    logic wr_ctl, wr_data;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign page = addr_hi_q[6:1];
    assign loc = {addr_hi_q[0], addr_lo_q, 4'h0} >> 2;
    assign busy = (state_q != FEC_IDLE);
    assign wr_ctl = i_reg_wr && hit(i_reg_addr, `FEC_CONTROL_OFS);
    assign wr_data = i_reg_wr && hit(i_reg_addr, `FEC_WDATA_OFS);

    fec_lock_check u_lock (
        .i_lock(lock_q),
        .i_page(page),
        .o_protected(prot)
    );

    fec_timer #(.ERASE_CYCLES(ERASE_CYCLES)) u_timer (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_start(tim_start),
        .i_erase(tim_erase),
        .i_timing(timing_q),
        .o_done(tim_done)
    );

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        addr_lo_d = addr_lo_q;
        addr_hi_d = addr_hi_q;
        ctl_d = ctl_q;
        wdata_d = wdata_q;
        timing_d = timing_q;
        bcnt_d = bcnt_q;
        word_d = word_q;
        pend_wr_d = pend_wr_q;
        info_d = info_q;
        lock_d = lock_q;
        lock_used_d = lock_used_q;
        dma_d = 1'b0;
        erase_d = 1'b0;
        prog_d = 1'b0;
        tim_start = 1'b0;
        tim_erase = 1'b0;
        if (i_reg_wr) begin
            if (hit(i_reg_addr, `FEC_ADDR_LOW_OFS)) addr_lo_d = i_reg_wdata;
            if (hit(i_reg_addr, `FEC_ADDR_HIGH_OFS)) addr_hi_d = i_reg_wdata;
            if (hit(i_reg_addr, `FEC_TIMING_OFS)) timing_d = i_reg_wdata[5:0];
            if (hit(i_reg_addr, `FEC_CONTROL_OFS)) begin
                ctl_d = (ctl_q & ~`FEC_CTL_RW_MASK) | (i_reg_wdata & `FEC_CTL_RW_MASK);
            end
            if (hit(i_reg_addr, `FEC_WDATA_OFS)) wdata_d = i_reg_wdata;
        end
        if (i_chip_erase) begin
            lock_used_d = 1'b0;
            lock_d = 8'hFF;
        end
        case (state_q)
            FEC_IDLE: begin
                if (wr_ctl && i_reg_wdata[`FEC_CTL_ERASE]) begin
                    state_d = FEC_ERASE;
                    pend_wr_d = i_reg_wdata[`FEC_CTL_WRITE];
                    tim_start = 1'b1;
                    tim_erase = 1'b1;
                    erase_d = !prot;
                end else if (wr_ctl && i_reg_wdata[`FEC_CTL_WRITE]) begin
                    state_d = FEC_ARM;
                end
            end
            FEC_ERASE: begin
                erase_d = !prot && !tim_done;
                if (tim_done) begin
                    state_d = pend_wr_q ? FEC_ARM : FEC_IDLE;
                    pend_wr_d = 1'b0;
                end
            end
            FEC_ARM: begin
                // first dma request once write mode is entered
                dma_d = 1'b1;
                bcnt_d = 2'd0;
                // a debug-locked part must not reach the info page
                info_d = i_dbg_access && i_dbg_info_page && lock_q[`FEC_LOCK_DBG];
                state_d = FEC_COLLECT;
            end
            FEC_COLLECT: begin
                if (wr_data) begin
                    word_d = {i_reg_wdata, word_q[31:8]};
                    bcnt_d = bcnt_q + 2'd1;
                    if (bcnt_q == 2'd3) begin
                        state_d = FEC_PROG;
                        tim_start = 1'b1;
                    end
                end
            end
            FEC_PROG: begin
                // info page writes to location zero land in the lock byte, once per chip erase
                prog_d = !tim_done && !info_q && !prot;
                if (tim_done) begin
                    if (info_q && i_dbg_access && !lock_used_q
                        && (loc == `FEC_INFO_LOCK_ADDR)) begin
                        lock_d = word_q[7:0] & ~`FEC_LOCK_RSV_MASK;
                        lock_used_d = 1'b1;
                    end
                    addr_lo_d = addr_lo_q + 8'h04;
                    if (addr_lo_q >= 8'hFC) addr_hi_d = addr_hi_q + 8'h01;
                    dma_d = 1'b1;
                    state_d = FEC_DONE;
                end
            end
            FEC_DONE: begin
                // words continue: the next byte stream is collected without a new start, until any control write here or one clearing the write bit between words
                state_d = FEC_COLLECT;
                if (wr_ctl && !i_reg_wdata[`FEC_CTL_WRITE]) state_d = FEC_IDLE;
                if (!wr_data && i_reg_wr && hit(i_reg_addr, `FEC_CONTROL_OFS)) begin
                    state_d = FEC_IDLE;
                end
            end
            default: state_d = FEC_IDLE;
        endcase
        if (state_q == FEC_COLLECT && wr_ctl && !i_reg_wdata[`FEC_CTL_WRITE]
            && bcnt_q == 2'd0) begin
            state_d = FEC_IDLE;
        end
    end

    // ****************************************
    // status, fetch stall and read port
    // ****************************************
    always_comb begin
        stall_d = i_fetch_from_flash && (state_d == FEC_ERASE || state_d == FEC_PROG);
        // registered so the pin never glitches with the fetch input
        rden_d = ctl_d[`FEC_CTL_CRD] || i_fetch_from_flash;
        rdata_d = 8'h00;
        if (i_reg_rd) begin
            case (1'b1)
                hit(i_reg_addr, `FEC_ADDR_LOW_OFS): rdata_d = addr_lo_d;
                hit(i_reg_addr, `FEC_ADDR_HIGH_OFS): rdata_d = addr_hi_d;
                hit(i_reg_addr, `FEC_WDATA_OFS): rdata_d = wdata_d;
                hit(i_reg_addr, `FEC_TIMING_OFS): rdata_d = {2'b00, timing_d};
                hit(i_reg_addr, `FEC_CONTROL_OFS): begin
                    rdata_d = ctl_d & `FEC_CTL_RW_MASK;
                    rdata_d[`FEC_CTL_BUSY] = (state_d != FEC_IDLE);
                    rdata_d[`FEC_CTL_SWP] = (state_d == FEC_PROG);
                end
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= FEC_IDLE;
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
            ctl_q <= 8'h00;
            wdata_q <= 8'h00;
            timing_q <= `FEC_TIMING_RST;
            bcnt_q <= 2'd0;
            word_q <= 32'h0;
            pend_wr_q <= 1'b0;
            info_q <= 1'b0;
            lock_q <= 8'hFF;
            lock_used_q <= 1'b0;
            stall_q <= 1'b0;
            dma_q <= 1'b0;
            erase_q <= 1'b0;
            prog_q <= 1'b0;
            rdata_q <= 8'h00;
            rden_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_lo_q <= addr_lo_d;
            addr_hi_q <= addr_hi_d;
            ctl_q <= ctl_d;
            wdata_q <= wdata_d;
            timing_q <= timing_d;
            bcnt_q <= bcnt_d;
            word_q <= word_d;
            pend_wr_q <= pend_wr_d;
            info_q <= info_d;
            lock_q <= lock_d;
            lock_used_q <= lock_used_d;
            stall_q <= stall_d;
            dma_q <= dma_d;
            erase_q <= erase_d;
            prog_q <= prog_d;
            rdata_q <= rdata_d;
            rden_q <= rden_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_fetch_stall = stall_q;
    assign o_dbg_enable = lock_q[`FEC_LOCK_DBG];
    assign o_dma_trigger = dma_q;
    assign o_flash_erase = erase_q;
    assign o_flash_prog = prog_q;
    assign o_flash_info = info_q;
    assign o_flash_page = addr_hi_q[6:1];
    assign o_flash_row = {addr_hi_q[0], addr_lo_q[7:6]};
    assign o_flash_word = addr_lo_q[5:0];
    assign o_flash_wdata = word_q;
    assign o_flash_read_en = rden_q;

    // ****************************************
    // checks
    // ****************************************
    sequence s_erase_req;
        wr_ctl && i_reg_wdata[`FEC_CTL_ERASE] && !busy;
    endsequence
    a_erase_entry: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        s_erase_req |=> state_q == FEC_ERASE)
        else $error("erase request not taken");
    a_erase_first: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == FEC_ERASE && pend_wr_q && tim_done) |=> state_q == FEC_ARM)
        else $error("write not after erase");
    a_busy_ignore: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == FEC_ERASE && !tim_done) |=> state_q == FEC_ERASE)
        else $error("erase left early");
    a_prot_erase: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == FEC_ERASE && prot) |=> !erase_q)
        else $error("locked page erased");
    a_word_four: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == FEC_COLLECT && wr_data && bcnt_q == 2'd3) |=> state_q == FEC_PROG)
        else $error("word not programmed");
    a_dma_commit: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == FEC_PROG && tim_done) |=> o_dma_trigger)
        else $error("no dma after commit");
    a_timing_reset: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $rose(i_rst_b) |-> timing_q == `FEC_TIMING_RST)
        else $error("timing reset wrong");
    a_data_gate: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (state_q == FEC_IDLE) |=> word_q == $past(word_q))
        else $error("data taken without start");
endmodule

// ==== testbench/fec_flash_model.sv ====
`timescale 1ns/10ps
// ****************************************
// flash array: records erases and programmed words
// ****************************************
module fec_flash_model (
    // clock
    input wire logic i_clock,
    // array controls
    input wire logic i_erase,
    input wire logic i_prog,
    input wire logic i_info,
    input wire logic [5:0] i_page,
    input wire logic [2:0] i_row,
    input wire logic [5:0] i_word,
    input wire logic [31:0] i_wdata
);
    // words keyed by info flag, page, row and location
    logic [31:0] mem[int];
    int ops[$];
    int erase_cnt = 0;
    int erase_len = 0;
    int run = 0;
    logic [5:0] erase_page = 6'h00;
    logic erase_q = 1'h0;
    logic prog_q = 1'h0;
    always @(posedge i_clock) begin
        if (i_erase) begin
            run = run + 1;
        end else if (erase_q) begin
            erase_len = run;
            run = 0;
        end
        if (i_erase && !erase_q) begin
            erase_cnt = erase_cnt + 1;
            erase_page = i_page;
            ops.push_back(1);
        end
        if (i_prog && !prog_q) begin
            mem[int'({i_info, i_page, i_row, i_word})] = i_wdata;
            ops.push_back(2);
        end
        erase_q = i_erase;
        prog_q = i_prog;
    end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`include "fec_regs.svh"
module tb_top;
    // short erase count keeps the run brief
    localparam int E = 210;
    logic i_clock = 1'h0;
    logic i_rst_b = 1'h0;
    logic i_reg_wr = 1'h0;
    logic i_reg_rd = 1'h0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_fetch_from_flash = 1'h0;
    logic i_dbg_access = 1'h0;
    logic i_dbg_info_page = 1'h0;
    logic i_chip_erase = 1'h0;
    logic [7:0] o_reg_rdata;
    logic o_fetch_stall, o_dbg_enable, o_dma_trigger, o_flash_erase, o_flash_prog;
    logic o_flash_info, o_flash_read_en;
    logic [5:0] o_flash_page, o_flash_word;
    logic [2:0] o_flash_row;
    logic [31:0] o_flash_wdata;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'h0;
    logic [31:0] seed = 32'h000023DF;
    int dma_cnt = 0;
    int miscompares = 0;
    int checks = 0;

    fec_controller #(.ERASE_CYCLES(E)) dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_fetch_from_flash(i_fetch_from_flash), .o_fetch_stall(o_fetch_stall),
        .i_dbg_access(i_dbg_access), .i_dbg_info_page(i_dbg_info_page),
        .i_chip_erase(i_chip_erase), .o_dbg_enable(o_dbg_enable),
        .o_dma_trigger(o_dma_trigger), .o_flash_erase(o_flash_erase),
        .o_flash_prog(o_flash_prog), .o_flash_info(o_flash_info),
        .o_flash_page(o_flash_page), .o_flash_row(o_flash_row), .o_flash_word(o_flash_word),
        .o_flash_wdata(o_flash_wdata), .o_flash_read_en(o_flash_read_en)
    );
    fec_flash_model fm (
        .i_clock(i_clock), .i_erase(o_flash_erase), .i_prog(o_flash_prog),
        .i_info(o_flash_info), .i_page(o_flash_page), .i_row(o_flash_row),
        .i_word(o_flash_word), .i_wdata(o_flash_wdata)
    );

    initial begin
        forever #2.5 i_clock = ~i_clock;
    end

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // read data stands from the taking edge and is checked at the next falling edge
    always @(posedge i_clock) begin
        rd_seen <= i_reg_rd;
        if (o_dma_trigger === 1'h1) dma_cnt <= dma_cnt + 1;
    end
    always @(negedge i_clock) begin
        if (rd_seen) chk(o_reg_rdata, exp_q.pop_front());
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1);
        i_reg_wr = 1'h1;
        i_reg_addr = a;
        i_reg_wdata = d;
        cyc(1);
        i_reg_wr = 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cyc(1);
        i_reg_rd = 1'h1;
        i_reg_addr = a;
        cyc(1);
        i_reg_rd = 1'h0;
    endtask

    task automatic wait_dma(input int target);
        int n;
        n = 0;
        while (dma_cnt < target) begin
            cyc(1);
            n++;
            if (n > 9000) begin
                miscompares++;
                report_and_stop();
            end
        end
    endtask

    task automatic erase(input logic [5:0] p, input logic [5:0] t, input logic prot);
        int c;
        c = fm.erase_cnt;
        wr(`FEC_ADDR_HIGH_OFS, {1'h0, p, 1'h0});
        wr(`FEC_CONTROL_OFS, 8'h01);
        if (!prot) begin
            rd(`FEC_CONTROL_OFS, 8'h80);
            chk(o_flash_page, p);
            chk(o_fetch_stall, i_fetch_from_flash);
        end
        cyc(E * t / 42 + 6);
        rd(`FEC_CONTROL_OFS, 8'h00);
        chk(o_fetch_stall, 1'h0);
        chk(fm.erase_cnt - c, !prot);
        if (!prot) begin
            chk(fm.erase_page, p);
            chk(fm.erase_len >= E * t / 42 && fm.erase_len <= E * t / 42 + 2, 1'h1);
        end
    endtask

    task automatic prog(input logic [7:0] ah, input logic [7:0] al, input logic [7:0] ctl,
                        input int n, input logic [7:0] b0);
        logic [31:0] w[$];
        logic [31:0] v;
        logic [15:0] a;
        int d;
        d = dma_cnt;
        wr(`FEC_ADDR_HIGH_OFS, ah);
        wr(`FEC_ADDR_LOW_OFS, al);
        fm.ops.delete();
        wr(`FEC_CONTROL_OFS, ctl);
        for (int i = 0; i < n; i++) begin
            v = rnd();
            if (i == 0) v[7:0] = b0;
            wait_dma(d + i + 1);
            for (int k = 0; k < 4; k++) wr(`FEC_WDATA_OFS, v[8*k+:8]);
            rd(`FEC_CONTROL_OFS, 8'hC0);
            w.push_back(v);
        end
        wait_dma(d + n + 1);
        wr(`FEC_CONTROL_OFS, 8'h00);
        for (int i = 0; i < n; i++) begin
            a = {1'h0, ah[6:0], al} + 16'(4 * i);
            // info page words land in the lock byte only at location zero, once per chip erase, never in the main array
            if (i_dbg_access & i_dbg_info_page) begin
                chk(fm.ops.size(), 0);
                chk(o_flash_info, 1'h1);
            end else begin
                chk(fm.mem[int'({1'h0, a[14:0]})], w[i]);
            end
        end
    endtask

    task automatic lock_wr(input logic [7:0] lk);
        i_dbg_access = 1'h1;
        i_dbg_info_page = 1'h1;
        prog(8'h00, 8'h00, 8'h02, 1, lk);
        i_dbg_access = 1'h0;
        i_dbg_info_page = 1'h0;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] v;
        logic [7:0] lk;
        int lo;
        int n;
        int pg[3];
        cyc(6);
        i_rst_b = 1'h1;
        chk(o_dbg_enable, 1'h1);
        rd(`FEC_TIMING_OFS, 8'h2A);
        rd(`FEC_ADDR_LOW_OFS, 8'h00);
        rd(`FEC_ADDR_HIGH_OFS, 8'h00);
        rd(`FEC_CONTROL_OFS, 8'h00);
        rd(`FEC_WDATA_OFS, 8'h00);
        rd(8'h00, 8'h00);
        v = rnd();
        wr(`FEC_ADDR_LOW_OFS, v[7:0]);
        rd(`FEC_ADDR_LOW_OFS, v[7:0]);
        wr(`FEC_ADDR_HIGH_OFS, {1'h0, v[14:8]});
        rd(`FEC_ADDR_HIGH_OFS, {1'h0, v[14:8]});
        n = fm.ops.size();
        for (int k = 0; k < 4; k++) wr(`FEC_WDATA_OFS, v[8*k+:8]);
        rd(`FEC_WDATA_OFS, v[31:24]);
        cyc(2);
        chk(fm.ops.size(), n);
        wr(`FEC_CONTROL_OFS, 8'h1C);
        rd(`FEC_CONTROL_OFS, 8'h1C);
        chk(o_flash_read_en, 1'h1);
        wr(`FEC_CONTROL_OFS, 8'h00);
        chk(o_flash_read_en, 1'h0);
        i_fetch_from_flash = 1'h1;
        erase(6'h05, 6'h2A, 1'h0);
        i_fetch_from_flash = 1'h0;
        wr(`FEC_TIMING_OFS, 8'h15);
        erase(6'h05, 6'h15, 1'h0);
        wr(`FEC_TIMING_OFS, 8'h2A);
        n = dma_cnt;
        wr(`FEC_CONTROL_OFS, 8'h01);
        wr(`FEC_CONTROL_OFS, 8'h02);
        cyc(E + 8);
        rd(`FEC_CONTROL_OFS, 8'h00);
        chk(dma_cnt, n);
        v = rnd();
        prog(8'h0A, 8'h40, 8'h03, 3, v[7:0]);
        chk(fm.ops[0], 1);
        chk(fm.ops[1], 2);
        // every lock size, then the boot page lock alone
        for (int s = 0; s < 9; s++) begin
            lk = (s < 8) ? {4'h1, s[2:0], s[0]} : 8'h0F;
            lo = 64 - (64 >> lk[3:1]);
            pg[0] = 0;
            pg[1] = (lo > 0) ? lo - 1 : 0;
            pg[2] = (lo < 64) ? lo : 63;
            cyc(1);
            i_chip_erase = 1'h1;
            cyc(1);
            i_chip_erase = 1'h0;
            lock_wr(lk);
            chk(o_dbg_enable, lk[0]);
            for (int j = 0; j < 3; j++) begin
                erase(6'(pg[j]), 6'h2A, (!lk[4] && pg[j] == 0) || pg[j] >= lo);
            end
        end
        // a second lock write after the first must not reopen page 0
        lock_wr(8'h1F);
        erase(6'h00, 6'h2A, 1'h1);
        report_and_stop();
    end
endmodule
